// ==== logic/lrc_pkg.sv ====
// Package of register offsets, fields, reset values and types for the block.
`default_nettype none
package lrc_pkg;
	localparam logic [15:0] LRC_OFS_FAULT_HWC = 16'h407d;
	localparam logic [15:0] LRC_OFS_ON_SETUP = 16'h407e;
	localparam logic [15:0] LRC_OFS_SLP_SETUP = 16'h407f;
	localparam logic [15:0] LRC_OFS_IRQ_STATUS = 16'h4090;
	localparam logic [15:0] LRC_OFS_IRQ_MASK = 16'h4091;
	localparam logic [15:0] LRC_RST_FAULT_HWC = 16'h0200;
	localparam logic [15:0] LRC_RST_ON_SETUP = 16'h0000;
	localparam logic [15:0] LRC_RST_SLP_SETUP = 16'h0100;
	localparam logic [15:0] LRC_RST_IRQ_MASK = 16'h0000;
	localparam logic [15:0] LRC_FAULT_HWC_MASK = 16'hdfc0;
	localparam logic [15:0] LRC_SETUP_MASK = 16'he11f;
	localparam int LRC_BIT_UV_EVENT = 0;
	localparam int LRC_SYNC_STAGES = 2;
	typedef enum logic [1:0] {
		LRC_UV_IGNORE,
		LRC_UV_OFF_REG,
		LRC_UV_OFF_SYS,
		LRC_UV_RESERVED
	} lrc_uv_action_t;
	typedef struct packed {
		lrc_uv_action_t undervoltageAction;
		logic spare13;
		logic [1:0] hwControlSource;
		logic hwControlVoltageChoice;
		logic [1:0] hwControlBehaviour;
		logic outputFloatWhenOff;
		logic switchStyleSelect;
		logic [5:0] spareLow;
	} lrc_fault_hwc_t;
	typedef struct packed {
		logic [2:0] slot;
		logic [3:0] spareHigh;
		logic powerMode;
		logic [2:0] spareMid;
		logic [4:0] voltage;
	} lrc_setup_t;
	typedef struct packed {
		logic enable;
		logic lowPower;
		logic [4:0] voltage;
		logic discharge;
		logic switchMode;
	} lrc_reg_drive_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} lrc_bus_req_t;
endpackage
`default_nettype wire

// ==== logic/lrc_regulator_ctrl.sv ====
// Control registers and control decode for one linear regulator.
`default_nettype none
module lrc_regulator_ctrl
	import lrc_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [15:0] busAddr,
	input wire logic [15:0] busWdata,
	input wire logic busWr,
	input wire logic busRd,
	output logic [15:0] busRdata,
	input wire logic underVoltage,
	input wire logic hwControl1,
	input wire logic hwControl2,
	input wire logic hwEnable1,
	input wire logic hwEnable2,
	input wire logic seqStartup,
	input wire logic seqSleep,
	input wire logic [2:0] seqSlot,
	input wire logic seqSlotStrobe,
	output lrc_reg_drive_t regDrive,
	output logic [9:0] voltageMillivoltsDiv5,
	output logic systemResetReq,
	output logic irq
);
	// ------------------------------------------------------------
	// Reset release and input synchronisers
	// ------------------------------------------------------------
	logic [1:0] rstSync_reg;
	logic rstnInt;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rstSync_reg <= 2'h0;
		end else begin
			rstSync_reg <= {rstSync_reg[0], 1'b1};
		end
	end
	assign rstnInt = rstSync_reg[1];

	logic [4:0] pinMeta_reg;
	logic [4:0] pinSync_reg;
	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			pinMeta_reg <= 5'h00;
			pinSync_reg <= 5'h00;
		end else begin
			pinMeta_reg <= {underVoltage, hwControl1, hwControl2,
				hwEnable1, hwEnable2};
			pinSync_reg <= pinMeta_reg;
		end
	end
	logic uvSync;
	logic hwc1;
	logic hwc2;
	logic hwe1;
	logic hwe2;
	assign {uvSync, hwc1, hwc2, hwe1, hwe2} = pinSync_reg;

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	lrc_fault_hwc_t faultHwc_reg;
	lrc_setup_t onSetup_reg;
	lrc_setup_t slpSetup_reg;
	logic [15:0] irqMask_reg;
	logic [15:0] irqStatus_reg;
	logic uvPrev_reg;
	logic uvEvent;

	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------
	logic wrFaultHwc;
	logic wrOnSetup;
	logic wrSlpSetup;
	logic wrIrqMask;
	logic wrIrqStatus;
	assign wrFaultHwc = busWr && busAddr == LRC_OFS_FAULT_HWC;
	assign wrOnSetup = busWr && busAddr == LRC_OFS_ON_SETUP;
	assign wrSlpSetup = busWr && busAddr == LRC_OFS_SLP_SETUP;
	assign wrIrqMask = busWr && busAddr == LRC_OFS_IRQ_MASK;
	assign wrIrqStatus = busWr && busAddr == LRC_OFS_IRQ_STATUS;

	// Reserved bits are dropped on write so that they always read zero.
	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			faultHwc_reg <= lrc_fault_hwc_t'(LRC_RST_FAULT_HWC);
		end else if (wrFaultHwc) begin
			faultHwc_reg <=
				lrc_fault_hwc_t'(busWdata & LRC_FAULT_HWC_MASK);
		end
	end

	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			onSetup_reg <= lrc_setup_t'(LRC_RST_ON_SETUP);
		end else if (wrOnSetup) begin
			onSetup_reg <= lrc_setup_t'(busWdata & LRC_SETUP_MASK);
		end
	end

	// Sleep mode resets to low power and voltage to code zero.
	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			slpSetup_reg <= lrc_setup_t'(LRC_RST_SLP_SETUP);
		end else if (wrSlpSetup) begin
			slpSetup_reg <= lrc_setup_t'(busWdata & LRC_SETUP_MASK);
		end
	end

	// Only the undervoltage bit exists in the mask.
	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			irqMask_reg <= LRC_RST_IRQ_MASK;
		end else if (wrIrqMask) begin
			irqMask_reg <= busWdata & 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------

	// An undervoltage event is a rising edge of the synchronised flag.
	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			uvPrev_reg <= 1'b0;
		end else begin
			uvPrev_reg <= uvSync;
		end
	end
	assign uvEvent = uvSync && !uvPrev_reg;

	// Status is sticky, cleared by writing one; a new event wins.
	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			irqStatus_reg <= 16'h0000;
		end else begin
			if (wrIrqStatus) begin
				irqStatus_reg <= irqStatus_reg & ~busWdata;
			end
			if (uvEvent) begin
				irqStatus_reg[LRC_BIT_UV_EVENT] <= 1'b1;
			end
		end
	end
	assign irq = |(irqStatus_reg & irqMask_reg);

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic [15:0] readNext;
	always_comb begin
		readNext = 16'h0000;
		if (busRd) begin
			case (busAddr)
				LRC_OFS_FAULT_HWC: readNext = faultHwc_reg;
				LRC_OFS_ON_SETUP: readNext = onSetup_reg;
				LRC_OFS_SLP_SETUP: readNext = slpSetup_reg;
				LRC_OFS_IRQ_STATUS: readNext = irqStatus_reg;
				LRC_OFS_IRQ_MASK: readNext = irqMask_reg;
				default: readNext = 16'h0000;
			endcase
		end
	end

	// Read data stand for one cycle only and are zero otherwise.
	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			busRdata <= 16'h0000;
		end else begin
			busRdata <= readNext;
		end
	end

	// ------------------------------------------------------------
	// Undervoltage response
	// ------------------------------------------------------------
	logic uvShutdown_reg;
	logic startupFirstSlot;
	assign startupFirstSlot = seqStartup && seqSlotStrobe && seqSlot == 3'h1;

	// A regulator-only shutdown holds until a fresh start-up begins.
	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			uvShutdown_reg <= 1'b0;
		end else if (startupFirstSlot) begin
			uvShutdown_reg <= 1'b0;
		end else if (uvEvent &&
			faultHwc_reg.undervoltageAction == LRC_UV_OFF_REG) begin
			uvShutdown_reg <= 1'b1;
		end
	end

	// The system reset request is a single-cycle pulse per event.
	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			systemResetReq <= 1'b0;
		end else begin
			systemResetReq <= 1'b0;
			if (uvEvent) begin
				case (faultHwc_reg.undervoltageAction)
					LRC_UV_OFF_SYS: systemResetReq <= 1'b1;
					LRC_UV_RESERVED: ;
					default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Sequencer timeslots
	// ------------------------------------------------------------
	logic onByHwEnable;
	logic hwEnableLevel;
	logic seqOn_reg;
	logic inSleep_reg;
	assign onByHwEnable = onSetup_reg.slot[2] && onSetup_reg.slot[1];
	assign hwEnableLevel = onSetup_reg.slot[0] ? hwe2 : hwe1;

	logic [2:0] slpDisableSlot;
	logic [2:0] slpSleepSlot;
	logic slpIsDisable;
	always_comb begin
		slpDisableSlot = 3'h0;
		slpSleepSlot = 3'h0;
		slpIsDisable = 1'b0;
		case (slpSetup_reg.slot)
			3'h0: slpSleepSlot = 3'h5;
			3'h6: slpSleepSlot = 3'h3;
			3'h7: slpSleepSlot = 3'h1;
			default: begin
				if (onByHwEnable) begin
					slpSleepSlot = 3'h6 - slpSetup_reg.slot;
				end else begin
					slpIsDisable = 1'b1;
					slpDisableSlot = 3'h6 - slpSetup_reg.slot;
				end
			end
		endcase
	end

	// Sequencer enable: set in its start-up slot, cleared in its
	// sleep disable slot.
	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			seqOn_reg <= 1'b0;
		end else if (seqSlotStrobe && seqStartup) begin
			if (!onByHwEnable && onSetup_reg.slot != 3'h0 &&
				seqSlot == onSetup_reg.slot) begin
				seqOn_reg <= 1'b1;
			end
		end else if (seqSlotStrobe && seqSleep) begin
			if (slpIsDisable && seqSlot == slpDisableSlot) begin
				seqOn_reg <= 1'b0;
			end
		end
	end

	// Sleep settings apply from their slot until the next start-up.
	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			inSleep_reg <= 1'b0;
		end else if (seqSlotStrobe && seqStartup) begin
			inSleep_reg <= 1'b0;
		end else if (seqSlotStrobe && seqSleep) begin
			if (!slpIsDisable && seqSlot == slpSleepSlot) begin
				inSleep_reg <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Hardware control and output drive
	// ------------------------------------------------------------
	logic hwcActive;
	always_comb begin
		case (faultHwc_reg.hwControlSource)
			2'h1: hwcActive = hwc1;
			2'h2: hwcActive = hwc2;
			2'h3: hwcActive = hwc1 || hwc2;
			default: hwcActive = 1'b0;
		endcase
	end

	// Settings of the present sequence state, before hardware control.
	logic [4:0] stateVoltage;
	logic stateLowPower;
	assign stateVoltage = inSleep_reg ? slpSetup_reg.voltage
		: onSetup_reg.voltage;
	assign stateLowPower = inSleep_reg ? slpSetup_reg.powerMode
		: onSetup_reg.powerMode;

	// Hardware control overrides the state settings; an undervoltage
	// shutdown has the last word over every enable source.
	lrc_reg_drive_t driveNext;
	always_comb begin
		driveNext.enable = onByHwEnable ? hwEnableLevel : seqOn_reg;
		driveNext.lowPower = stateLowPower;
		driveNext.voltage = stateVoltage;
		if (hwcActive) begin
			driveNext.voltage = faultHwc_reg.hwControlVoltageChoice
				? slpSetup_reg.voltage
				: onSetup_reg.voltage;
			case (faultHwc_reg.hwControlBehaviour)
				2'h1: driveNext.enable = 1'b0;
				2'h3: driveNext.lowPower = onSetup_reg.powerMode;
				default: driveNext.lowPower = 1'b1;
			endcase
		end
		if (uvShutdown_reg) begin
			driveNext.enable = 1'b0;
		end
		driveNext.discharge = !driveNext.enable &&
			!faultHwc_reg.outputFloatWhenOff;
		driveNext.switchMode = faultHwc_reg.switchStyleSelect;
	end

	// Output voltage in 5 mV units: 1.0 V base, two step sizes.
	logic [9:0] mvNext;
	always_comb begin
		if (driveNext.voltage <= 5'h0c) begin
			mvNext = 10'd200 + 10'(driveNext.voltage) * 10'd10;
		end else begin
			mvNext = 10'd340 + 10'(driveNext.voltage - 5'h0d)
				* 10'd20;
		end
	end

	always_ff @(posedge mclk or negedge rstnInt) begin
		if (!rstnInt) begin
			regDrive <= '0;
			voltageMillivoltsDiv5 <= 10'd200;
		end else begin
			regDrive <= driveNext;
			voltageMillivoltsDiv5 <= mvNext;
		end
	end
endmodule
`default_nettype wire

// ==== test/lrc_regulator_ctrl_asserts.sv ====
// Port checker for the regulator control block.
`default_nettype none
module lrc_regulator_ctrl_asserts
	import lrc_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [15:0] busAddr,
	input wire logic busRd,
	input wire logic [15:0] busRdata,
	input wire lrc_reg_drive_t regDrive,
	input wire logic [9:0] voltageMillivoltsDiv5,
	input wire logic systemResetReq,
	input wire logic irq
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	rdata_idle_a: assert property (!$past(busRd) |-> busRdata == 16'h0)
		else $error("read data not zero outside a read");
	fault_resv_a: assert property ($past(busRd) &&
		$past(busAddr) == 16'h407d |-> (busRdata & 16'h203f) == 16'h0)
		else $error("reserved control bits read non-zero");
	setup_resv_a: assert property ($past(busRd) &&
		$past(busAddr) == 16'h407f |-> (busRdata & 16'h1ee0) == 16'h0)
		else $error("reserved sleep setup bits read non-zero");
	mv_low_a: assert property (regDrive.enable &&
		regDrive.voltage < 5'h0d |->
		voltageMillivoltsDiv5 == 10'd200 + 10'd10 * regDrive.voltage)
		else $error("low voltage code maps wrongly");
	mv_high_a: assert property (regDrive.enable &&
		regDrive.voltage > 5'h0c |->
		voltageMillivoltsDiv5 == 10'd80 + 10'd20 * regDrive.voltage)
		else $error("high voltage code maps wrongly");
	reset_pulse_a: assert property (systemResetReq |=> !systemResetReq)
		else $error("system reset request longer than one cycle");
	drive_dis_a: assert property (regDrive.enable |-> !regDrive.discharge)
		else $error("discharge while enabled");
	irq_status_a: assert property (irq && busRd &&
		busAddr == 16'h4090 |=> busRdata[0])
		else $error("interrupt without status bit");
endmodule
bind lrc_regulator_ctrl lrc_regulator_ctrl_asserts u_chk (
	.mclk, .rstn, .busAddr, .busRd, .busRdata, .regDrive,
	.voltageMillivoltsDiv5, .systemResetReq, .irq
);
`default_nettype wire

// ==== test/lrc_regulator_ctrl_tb.sv ====
// Self-checking bench for the regulator control registers.
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin \
	fail_count++; $display("Error %s exp %h got %h", n, e, a); end end
module lrc_regulator_ctrl_tb
	import lrc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = '0, rstn = '0, busWr = '0, busRd = '0, rdSeen = '0;
	logic underVoltage = '0, hwControl1 = '0, hwControl2 = '0;
	logic hwEnable1 = '0, hwEnable2 = '0, seqStartup = '0, seqSleep = '0;
	logic seqSlotStrobe = '0, systemResetReq, irq;
	logic [15:0] busAddr = '0, busWdata = '0, busRdata, expV;
	logic [2:0] seqSlot = '0;
	logic [9:0] voltageMillivoltsDiv5;
	lrc_reg_drive_t regDrive;
	logic [15:0] expQ[$];
	int fail_count = 0, n_checks = 0;
	lrc_regulator_ctrl u_dut (.mclk, .rstn, .busAddr, .busWdata, .busWr,
		.busRd, .busRdata, .underVoltage, .hwControl1, .hwControl2,
		.hwEnable1, .hwEnable2, .seqStartup, .seqSleep, .seqSlot,
		.seqSlotStrobe, .regDrive, .voltageMillivoltsDiv5,
		.systemResetReq, .irq);
	initial forever #10 mclk = ~mclk;
	always @(posedge mclk) rdSeen <= busRd;
	always @(negedge mclk) begin
		if (rdSeen) begin
			expV = expQ.pop_front();
			`CHK("busRdata", expV, busRdata)
		end
	end
	function automatic logic [9:0] mv(int v);
		return v < 13 ? 10'(200 + 10 * v) : 10'(80 + 20 * v);
	endfunction
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk);
		busAddr <= a;
		busWdata <= d;
		busWr <= 1'h1;
		@(posedge mclk);
		busWr <= 1'h0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		@(posedge mclk);
		expQ.push_back(e);
		busAddr <= a;
		busRd <= 1'h1;
		@(posedge mclk);
		busRd <= 1'h0;
	endtask
	// Strobes one sequencer slot, then waits for the drive to settle.
	task automatic stb(input logic up, input logic [2:0] s);
		@(posedge mclk);
		seqStartup <= up;
		seqSleep <= !up;
		seqSlot <= s;
		seqSlotStrobe <= 1'h1;
		@(posedge mclk);
		seqSlotStrobe <= 1'h0;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic hw(input logic [15:0] d, input logic e1);
		wr(LRC_OFS_FAULT_HWC, d);
		hwEnable1 <= e1;
		hwControl1 <= 1'h1;
		repeat (6) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic results;
		if (fail_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		logic [15:0] w;
		logic seen;
		int v;
		void'($urandom(32'hf6eb));
		repeat (12) @(posedge mclk);
		rstn <= 1'h1;
		repeat (3) @(posedge mclk);
		rd(16'h407d, 16'h0200);
		rd(16'h407e, 16'h0000);
		rd(16'h407f, 16'h0100);
		rd(16'h4092, 16'h0000);
		w = 16'($urandom);
		wr(16'h407d, w);
		rd(16'h407d, w & 16'hdfc0);
		wr(16'h407d, 16'h0000);
		for (int c = 1; c < 6; c++) begin
			v = $urandom_range(31);
			wr(16'h407e, {3'(c), 8'h00, 5'(v)});
			wr(16'h407f, {3'(6 - c), 13'h0000});
			for (int s = 1; s < 6; s++) begin
				stb(1'h1, 3'(s));
				`CHK("enable", s >= c, regDrive.enable)
			end
			`CHK("mv", mv(v), voltageMillivoltsDiv5)
			for (int s = 5; s > 0; s--) begin
				stb(1'h0, 3'(s));
				`CHK("enable", s > c, regDrive.enable)
			end
		end
		wr(16'h407e, 16'h2003);
		wr(16'h407f, 16'h0114);
		stb(1'h1, 3'h1);
		stb(1'h0, 3'h5);
		`CHK("lowPower", 1'h1, regDrive.lowPower)
		`CHK("mv", mv(20), voltageMillivoltsDiv5)
		for (int a = 0; a < 4; a++) begin
			wr(16'h4091, {15'h0000, a != 3});
			wr(16'h407d, {2'(a), 14'h0000});
			stb(1'h1, 3'h1);
			@(posedge mclk);
			underVoltage <= 1'h1;
			seen = 1'h0;
			for (int k = 0; k < 8; k++) begin
				@(negedge mclk);
				seen |= systemResetReq;
			end
			@(posedge mclk);
			underVoltage <= 1'h0;
			@(negedge mclk);
			`CHK("sysReset", a == 2, seen)
			`CHK("enable", a != 1, regDrive.enable)
			`CHK("discharge", a == 1, regDrive.discharge)
			`CHK("irq", a != 3, irq)
			rd(16'h4090, 16'h0001);
			wr(16'h4090, 16'h0001);
			@(negedge mclk);
			`CHK("irq", 1'h0, irq)
		end
		hw(16'h0000, 1'h1);
		wr(16'h407e, 16'hc003);
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		`CHK("enable", 1'h1, regDrive.enable)
		hw(16'h0f40, 1'h1);
		`CHK("mv", mv(20), voltageMillivoltsDiv5)
		`CHK("lowPower", 1'h0, regDrive.lowPower)
		`CHK("switchMode", 1'h1, regDrive.switchMode)
		hw(16'h0b40, 1'h1);
		`CHK("mv", mv(3), voltageMillivoltsDiv5)
		hw(16'h0940, 1'h1);
		`CHK("enable", 1'h0, regDrive.enable)
		hw(16'h0000, 1'h0);
		`CHK("enable", 1'h0, regDrive.enable)
		repeat (3) @(posedge mclk);
		results();
	end
endmodule
`default_nettype wire
